/* File: rtl/cgss_top.sv */
// Clock generator status, flags, interrupt enables and clock select.
// Assumes an AXI4-Lite master on sys_clk_i and event pulses from the
// synthesizer, timer and reset logic synchronous to the same clock.
// What this block does
// R1: Post divider divides VCO by twice value; zero passes VCO.
// R2: Post divider write ignored while synth selected.
// R3: Timer flag sets on timeout, W1C, interrupts.
// R4: Power-on flag set by POR, W1C only.
// R5: Brownout flag set by LVR, W1C only.
// R6: Bad-address flag kept; cleared by POR/LVR/W1C.
// R7: Lock-change flag on lock edge, W1C, interrupts.
// R8: Lock bit read-only, zero in self clock.
// R9: Self-clock-change flag on status edge, W1C.
// R10: Self clock status bit read-only.
// R11: Enables at bits 7, 4, 1 gate interrupts.
// R12: Synth select bit written as zero while unlocked.
// R13: Synth select cleared on SELF_CLOCK_STATUS, stop, wait when synth_off_in_wait set.
// R14: Bus clock is half selected source.
// R15: Software should read back synth select.
// R16: Oscillator kept in stop when bit set.
// R17: Oscillator config status is read-only.
// R18: Synth powered down in wait when enabled.
// R19: Timer stops and reinitialises in wait when enabled.
// R20: Watchdog stops in wait when enabled; write-once normally.
// R21: Writing zero to a flag does nothing.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "cgss_map.svh"
module cgss_top import cgss_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic vco_clock_i,
  input wire logic oscillator_clock_i,
  input wire logic lock_raw_i,
  input wire logic self_clock_status_i,
  input wire logic periodic_timeout_i,
  input wire logic poweron_reset_i,
  input wire logic brownout_reset_i,
  input wire logic bad_address_reset_i,
  input wire logic osc_config_status_i,
  input wire logic special_mode_i,
  input wire logic synth_power_on_i,
  input wire logic wait_mode_i,
  input wire logic stop_mode_i,
  output logic synth_clock_o,
  output logic bus_clock_o,
  output logic system_from_synth_o,
  output logic irq_o,
  output logic synth_power_o,
  output logic osc_run_o,
  output logic timer_init_o,
  output logic timer_run_o,
  output logic watchdog_init_o,
  output logic watchdog_run_o
);
  cgss_state_t st_r;
  cgss_state_t st_nxt;
  logic lock_eff;
  logic aw_ok;
  logic w_ok;
  logic do_wr;
  logic [7:0] wb;
  logic [7:0] rsel;
  logic [7:0] flags_rd;
  logic [7:0] sel_rd;
  logic [7:0] half;

  // Lock is forced low in self clock mode. R8
  assign lock_eff = lock_raw_i & ~self_clock_status_i; // R8

  always_comb begin
    st_nxt = st_r;
    aw_ok = s_axi_awvalid_i & st_r.bus.awready;
    w_ok = s_axi_wvalid_i & st_r.bus.wready;
    if (aw_ok) begin
      st_nxt.bus.aw_done = 1'b1;
      st_nxt.bus.aw_idx = s_axi_awaddr_i[9:2];
    end
    if (w_ok) begin
      st_nxt.bus.w_done = 1'b1;
      st_nxt.bus.wdata = s_axi_wstrb_i[0] ? s_axi_wdata_i[7:0] : 8'h00;
    end
    do_wr = st_r.bus.aw_done & st_r.bus.w_done;
    wb = st_r.bus.wdata;
    flags_rd = {st_r.core.periodic_timeout_flag,
                st_r.core.poweron_reset_flag,
                st_r.core.brownout_reset_flag,
                st_r.core.lock_change_flag, lock_eff,
                st_r.core.bad_address_reset_flag,
                st_r.core.self_clock_change_flag,
                self_clock_status_i}; // R10
    // Oscillator configuration comes straight from the pin. R17
    sel_rd = {st_r.core.synth_clock_choose, st_r.core.osc_keep_in_stop,
              osc_config_status_i, 1'b0, st_r.core.synth_off_in_wait, // R17
              1'b0, st_r.core.timer_off_in_wait,
              st_r.core.watchdog_off_in_wait};
    if (do_wr) begin
      st_nxt.bus.aw_done = 1'b0;
      st_nxt.bus.w_done = 1'b0;
      st_nxt.bus.bvalid = 1'b1;
      st_nxt.bus.bresp = `CGSS_BUS_OKAY;
      unique case (st_r.bus.aw_idx)
        `CGSS_OFF_POST_DIVIDE_VALUE_IDX: begin
          if (!st_r.core.synth_clock_choose) begin // R2
            st_nxt.core.post_divide_value = wb & `CGSS_POST_DIVIDE_VALUE_MASK;
          end
        end
        `CGSS_OFF_FLAGS_IDX: begin
          // Ones clear, zeros leave the flag alone; set wins below. R21
          if (wb[`CGSS_FLG_TIMEOUT]) begin // R21
            st_nxt.core.periodic_timeout_flag = 1'b0;
          end
          if (wb[`CGSS_FLG_POWERON_RESET_FLAG]) begin
            st_nxt.core.poweron_reset_flag = 1'b0;
          end
          if (wb[`CGSS_FLG_BROWN]) begin
            st_nxt.core.brownout_reset_flag = 1'b0;
          end
          if (wb[`CGSS_FLG_LOCKCHG]) begin
            st_nxt.core.lock_change_flag = 1'b0;
          end
          if (wb[`CGSS_FLG_BADADDR]) begin
            st_nxt.core.bad_address_reset_flag = 1'b0;
          end
          if (wb[`CGSS_FLG_SCMCHG]) begin
            st_nxt.core.self_clock_change_flag = 1'b0;
          end
        end
        `CGSS_OFF_IRQEN_IDX: begin
          st_nxt.core.irq_en = wb & `CGSS_IRQEN_MASK; // R11
        end
        `CGSS_OFF_CLOCK_SOURCE_SELECT_IDX: begin
          // Unlocked synth must never become the system clock. R12
          st_nxt.core.synth_clock_choose =
            wb[`CGSS_SEL_SYNTH] & lock_eff; // R12
          st_nxt.core.osc_keep_in_stop = wb[`CGSS_SEL_PSTOP]; // R16
          st_nxt.core.synth_off_in_wait = wb[`CGSS_SEL_SYNWAI];
          st_nxt.core.timer_off_in_wait = wb[`CGSS_SEL_TMRWAI];
          if (special_mode_i || !st_r.core.wdg_written) begin // R20
            st_nxt.core.watchdog_off_in_wait = wb[`CGSS_SEL_WDGWAI];
            st_nxt.core.wdg_written = 1'b1;
          end
        end
        default: begin
          st_nxt.bus.bresp = `CGSS_BUS_SLVERR;
        end
      endcase
    end
    if (st_r.bus.bvalid && s_axi_bready_i) begin
      st_nxt.bus.bvalid = 1'b0;
    end
    unique case (s_axi_araddr_i[9:2])
      `CGSS_OFF_POST_DIVIDE_VALUE_IDX: rsel = st_r.core.post_divide_value;
      `CGSS_OFF_FLAGS_IDX: rsel = flags_rd;
      `CGSS_OFF_IRQEN_IDX: rsel = st_r.core.irq_en;
      `CGSS_OFF_CLOCK_SOURCE_SELECT_IDX: rsel = sel_rd;
      default: rsel = 8'h00;
    endcase
    unique case (st_r.bus.rd_st)
      CGSS_RD_IDLE: begin
        if (s_axi_arvalid_i && st_r.bus.arready) begin
          st_nxt.bus.rd_st = CGSS_RD_RESP;
          st_nxt.bus.rdata = rsel;
          st_nxt.bus.rresp = (s_axi_araddr_i[9:2] >= `CGSS_OFF_POST_DIVIDE_VALUE_IDX
            && s_axi_araddr_i[9:2] <= `CGSS_OFF_CLOCK_SOURCE_SELECT_IDX
            && s_axi_araddr_i[31:10] == 22'h0) ? `CGSS_BUS_OKAY
            : `CGSS_BUS_SLVERR;
        end
      end
      CGSS_RD_RESP: begin
        if (s_axi_rready_i) begin
          st_nxt.bus.rd_st = CGSS_RD_IDLE;
        end
      end
      default: st_nxt.bus.rd_st = CGSS_RD_IDLE;
    endcase

    // Hardware events; each set overrides a W1C clear in the same cycle.
    if (periodic_timeout_i) begin
      st_nxt.core.periodic_timeout_flag = 1'b1; // R3
    end
    st_nxt.core.lock_prev = lock_eff;
    if (lock_eff != st_r.core.lock_prev) begin
      st_nxt.core.lock_change_flag = 1'b1; // R7
    end
    st_nxt.core.scm_prev = self_clock_status_i;
    if (self_clock_status_i != st_r.core.scm_prev) begin
      st_nxt.core.self_clock_change_flag = 1'b1; // R9
    end
    if (poweron_reset_i) begin
      st_nxt.core.poweron_reset_flag = 1'b1; // R4
    end
    if (brownout_reset_i) begin
      st_nxt.core.brownout_reset_flag = 1'b1; // R5
    end
    if (poweron_reset_i || brownout_reset_i) begin
      st_nxt.core.bad_address_reset_flag = 1'b0; // R6
    end else if (bad_address_reset_i) begin
      st_nxt.core.bad_address_reset_flag = 1'b1; // R6
    end

    // Entry edges into stop, self clock, or wait with synth_off_in_wait set drop the synth selection. R13
    st_nxt.core.wait_prev = wait_mode_i;
    st_nxt.core.stop_prev = stop_mode_i;
    st_nxt.core.scm_enter_prev = self_clock_status_i;
    if ((self_clock_status_i && !st_r.core.scm_enter_prev) ||
        (stop_mode_i && !st_r.core.stop_prev) ||
        (wait_mode_i && !st_r.core.wait_prev &&
         st_r.core.synth_off_in_wait)) begin
      st_nxt.core.synth_clock_choose = 1'b0; // R13
    end

    st_nxt.core.irq =
      (st_r.core.periodic_timeout_flag &
       st_r.core.irq_en[`CGSS_FLG_TIMEOUT]) |
      (st_r.core.lock_change_flag & st_r.core.irq_en[`CGSS_FLG_LOCKCHG]) |
      (st_r.core.self_clock_change_flag &
       st_r.core.irq_en[`CGSS_FLG_SCMCHG]); // R11

    // Synth power: on bit stays, but power drops in wait when synth_off_in_wait is set. R18
    st_nxt.core.synth_pwr = (synth_power_on_i | self_clock_status_i) &
      ~(wait_mode_i & st_r.core.synth_off_in_wait); // R18
    st_nxt.core.osc_run = ~stop_mode_i | st_r.core.osc_keep_in_stop; // R16
    st_nxt.core.timer_init = wait_mode_i & st_r.core.timer_off_in_wait; // R19
    st_nxt.core.wdg_init = wait_mode_i & st_r.core.watchdog_off_in_wait; // R20
    st_nxt.core.timer_run = ~st_nxt.core.timer_init; // R19
    st_nxt.core.wdg_run = ~st_nxt.core.wdg_init; // R20
    // Ready flags are registered from next state, so they stay low for one
    // cycle after reset, and every top output but s_axi_rvalid_o comes straight from a flip-flop.
    st_nxt.bus.awready = ~st_nxt.bus.aw_done & ~st_nxt.bus.bvalid;
    st_nxt.bus.wready = ~st_nxt.bus.w_done & ~st_nxt.bus.bvalid;
    st_nxt.bus.arready = (st_nxt.bus.rd_st == CGSS_RD_IDLE);

    // Post divider toggles after every value cycles with the VCO sample high. R1
    half = st_r.core.post_divide_value;
    if (half == 8'h00) begin
      st_nxt.core.synth_clock = vco_clock_i; // R1
    end else if (vco_clock_i) begin
      if (st_r.core.div_cnt + 8'h01 >= half) begin
        st_nxt.core.div_cnt = 8'h00;
        st_nxt.core.synth_clock = ~st_r.core.synth_clock; // R1
      end else begin
        st_nxt.core.div_cnt = st_r.core.div_cnt + 8'h01;
      end
    end
    // Bus clock toggles on each synth rising edge, or each cycle the oscillator sample is high. R14
    if (st_r.core.synth_clock_choose ?
        (st_nxt.core.synth_clock & ~st_r.core.synth_clock) :
        oscillator_clock_i) begin
      st_nxt.core.bus_clock = ~st_r.core.bus_clock; // R14
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready_o = st_r.bus.awready;
  assign s_axi_wready_o = st_r.bus.wready;
  assign s_axi_bvalid_o = st_r.bus.bvalid;
  assign s_axi_bresp_o = st_r.bus.bresp;
  assign s_axi_arready_o = st_r.bus.arready;
  assign s_axi_rvalid_o = (st_r.bus.rd_st == CGSS_RD_RESP);
  assign s_axi_rdata_o = {24'h000000, st_r.bus.rdata};
  assign s_axi_rresp_o = st_r.bus.rresp;
  assign synth_clock_o = st_r.core.synth_clock;
  assign bus_clock_o = st_r.core.bus_clock;
  assign system_from_synth_o = st_r.core.synth_clock_choose;
  assign irq_o = st_r.core.irq;
  assign synth_power_o = st_r.core.synth_pwr;
  assign osc_run_o = st_r.core.osc_run;
  assign timer_init_o = st_r.core.timer_init;
  assign timer_run_o = st_r.core.timer_run;
  assign watchdog_init_o = st_r.core.wdg_init;
  assign watchdog_run_o = st_r.core.wdg_run;
endmodule

/* File: common/cgss_map.svh */
// Register map, field positions, masks, reset value and bus response codes.
// Assumes inclusion by the design module only.
`ifndef CGSS_MAP_SVH
`define CGSS_MAP_SVH
`define CGSS_OFF_POST_DIVIDE_VALUE_IDX 8'h02
`define CGSS_OFF_FLAGS_IDX 8'h03
`define CGSS_OFF_IRQEN_IDX 8'h04
`define CGSS_OFF_CLOCK_SOURCE_SELECT_IDX 8'h05
`define CGSS_FLG_TIMEOUT 7
`define CGSS_FLG_POWERON_RESET_FLAG 6
`define CGSS_FLG_BROWN 5
`define CGSS_FLG_LOCKCHG 4
`define CGSS_FLG_LOCK 3
`define CGSS_FLG_BADADDR 2
`define CGSS_FLG_SCMCHG 1
`define CGSS_FLG_SCM 0
`define CGSS_SEL_SYNTH 7
`define CGSS_SEL_PSTOP 6
`define CGSS_SEL_OSCCFG 5
`define CGSS_SEL_SYNWAI 3
`define CGSS_SEL_TMRWAI 1
`define CGSS_SEL_WDGWAI 0
`define CGSS_IRQEN_MASK 8'h92
`define CGSS_POST_DIVIDE_VALUE_MASK 8'h1F
`define CGSS_RESET_BYTE 8'h00
`define CGSS_BUS_OKAY 2'h0
`define CGSS_BUS_SLVERR 2'h2
`endif

/* File: common/cgss_pkg.sv */
// Types shared by the clock status and select block.
// Assumes cgss_map.svh is on the include path.
package cgss_pkg;
  typedef enum logic [1:0] {
    CGSS_RD_IDLE = 2'b00,
    CGSS_RD_RESP = 2'b01
  } cgss_rd_st_t;

  typedef struct packed {
    logic [7:0] post_divide_value;
    logic periodic_timeout_flag;
    logic poweron_reset_flag;
    logic brownout_reset_flag;
    logic lock_change_flag;
    logic bad_address_reset_flag;
    logic self_clock_change_flag;
    logic lock_prev;
    logic scm_prev;
    logic [7:0] irq_en;
    logic synth_clock_choose;
    logic osc_keep_in_stop;
    logic synth_off_in_wait;
    logic timer_off_in_wait;
    logic watchdog_off_in_wait;
    logic wdg_written;
    logic wait_prev;
    logic stop_prev;
    logic scm_enter_prev;
    logic [7:0] div_cnt;
    logic synth_clock;
    logic bus_clock;
    logic irq;
    logic timer_init;
    logic wdg_init;
    logic synth_pwr;
    logic osc_run;
    logic timer_run;
    logic wdg_run;
  } cgss_core_t;

  typedef struct packed {
    logic aw_done;
    logic w_done;
    logic [7:0] aw_idx;
    logic [7:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    cgss_rd_st_t rd_st;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic awready;
    logic wready;
    logic arready;
  } cgss_bus_t;

  typedef struct packed {
    cgss_core_t core;
    cgss_bus_t bus;
  } cgss_state_t;
endpackage

/* File: tb/cgss_top_sva.sv */
// Port-level checker for the clock status and select block.
// Assumes a bind to cgss_top; every watched port keeps its own name.
`timescale 1ns/1ps
module cgss_chk (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic lock_raw_i,
  input wire logic self_clock_status_i,
  input wire logic oscillator_clock_i,
  input wire logic stop_mode_i,
  input wire logic wait_mode_i,
  input wire logic synth_power_on_i,
  input wire logic system_from_synth_o,
  input wire logic bus_clock_o,
  input wire logic synth_power_o,
  input wire logic osc_run_o,
  input wire logic timer_init_o,
  input wire logic timer_run_o,
  input wire logic watchdog_init_o,
  input wire logic watchdog_run_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_sel_lock;
    $rose(system_from_synth_o) |->
      $past(lock_raw_i) && !$past(self_clock_status_i);
  endproperty
  a_sel_lock: assert property (p_sel_lock)
    else $error("synth select rose while unlocked");
  property p_sel_stop;
    $rose(stop_mode_i) |-> ##[1:2] !system_from_synth_o;
  endproperty
  a_sel_stop: assert property (p_sel_stop)
    else $error("synth select kept in stop");
  property p_sel_scm;
    $rose(self_clock_status_i) |-> ##[1:2] !system_from_synth_o;
  endproperty
  a_sel_scm: assert property (p_sel_scm)
    else $error("synth select kept in self clock");
  // Only checked while the oscillator runs and neither stop nor wait is set.
  property p_bus_osc;
    !system_from_synth_o && $stable(system_from_synth_o) && osc_run_o
      && !wait_mode_i && !stop_mode_i && oscillator_clock_i
      |=> $changed(bus_clock_o);
  endproperty
  a_bus_osc: assert property (p_bus_osc)
    else $error("bus clock missed an oscillator toggle");
  property p_tmr;
    timer_init_o |-> $past(wait_mode_i) && !timer_run_o;
  endproperty
  a_tmr: assert property (p_tmr)
    else $error("timer init outside wait");
  property p_wdg;
    watchdog_init_o |-> $past(wait_mode_i) && !watchdog_run_o;
  endproperty
  a_wdg: assert property (p_wdg)
    else $error("watchdog init outside wait");
  property p_pwr;
    synth_power_o |-> $past(synth_power_on_i) || $past(self_clock_status_i);
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("synth powered without its on bit");
  property p_osc;
    !osc_run_o && $past(resetn_i) |-> $past(stop_mode_i);
  endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator off outside stop");
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the clock status and select block.
// Assumes cgss_top with an AXI4-Lite slave on one 40 MHz clock.
`timescale 1ns/1ps
module testbench;
  logic sys_clk_i, resetn_i, s_axi_awvalid_i, s_axi_wvalid_i;
  logic s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
  logic [31:0] s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i;
  logic [3:0] s_axi_wstrb_i;
  logic vco_clock_i, oscillator_clock_i, lock_raw_i, self_clock_status_i;
  logic periodic_timeout_i, poweron_reset_i, brownout_reset_i;
  logic bad_address_reset_i, osc_config_status_i, special_mode_i;
  logic synth_power_on_i, wait_mode_i, stop_mode_i;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, synth_clock_o, bus_clock_o, system_from_synth_o;
  logic irq_o, synth_power_o, osc_run_o, timer_init_o, timer_run_o;
  logic watchdog_init_o, watchdog_run_o, ps, pv;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic [31:0] lfsr = 32'hFF8E7F95;
  logic [7:0] d;
  logic [9:0] exp_q[$];
  int err_total, checks_done;
  cgss_top uut (.*);
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  function automatic logic [31:0] lfsr_next(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Clock levels come from the shift register so both dividers see jitter.
  always @(posedge sys_clk_i) begin
    lfsr <= lfsr_next(lfsr);
    vco_clock_i <= lfsr[0];
    oscillator_clock_i <= lfsr[5];
  end
  task automatic chk(string nm, logic [9:0] e, logic [9:0] s);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  always @(posedge sys_clk_i)
    if (s_axi_rvalid_o && s_axi_rready_i)
      chk("rdata", exp_q.pop_front(), {s_axi_rresp_o, s_axi_rdata_o[7:0]});
  task automatic wr(logic [7:0] a, logic [7:0] v);
    logic [9:0] e;
    e = (a >= 8'h02 && a <= 8'h05) ? 10'h000 : 10'h002;
    @(posedge sys_clk_i);
    s_axi_awaddr_i <= {22'h0, a, 2'h0};
    s_axi_wdata_i <= {24'h0, v};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_awvalid_i && !s_axi_awready_o
               || s_axi_wvalid_i && !s_axi_wready_o);
    while (!s_axi_bvalid_o) @(posedge sys_clk_i);
    chk("bresp", e, {8'h00, s_axi_bresp_o});
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [9:0] e);
    @(posedge sys_clk_i);
    s_axi_araddr_i <= {22'h0, a, 2'h0};
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    exp_q.push_back(e);
    do @(posedge sys_clk_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 1'b0;
    while (!s_axi_rvalid_o) @(posedge sys_clk_i);
    s_axi_rready_i <= 1'b0;
  endtask
  // Event codes: 0 power-on, 1 bad address, 2 brownout, 3 timeout.
  task automatic pulse(int k);
    @(posedge sys_clk_i);
    poweron_reset_i <= (k == 0);
    bad_address_reset_i <= (k == 1);
    brownout_reset_i <= (k == 2);
    periodic_timeout_i <= (k == 3);
    @(posedge sys_clk_i);
    {poweron_reset_i, bad_address_reset_i, brownout_reset_i,
     periodic_timeout_i} <= 4'h0;
  endtask
  task automatic settle;
    repeat (3) @(posedge sys_clk_i);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_total++;
    close_out;
  end
  initial begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i,
     s_axi_rready_i, lock_raw_i, self_clock_status_i, periodic_timeout_i,
     poweron_reset_i, brownout_reset_i, bad_address_reset_i, resetn_i,
     special_mode_i, synth_power_on_i, wait_mode_i, stop_mode_i} = '0;
    {s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i} = '0;
    {vco_clock_i, oscillator_clock_i} = 2'h0;
    s_axi_wstrb_i = 4'hF;
    osc_config_status_i = 1'b1;
    repeat (20) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    rd(8'h05, 10'h020);
    pulse(0);
    rd(8'h03, 10'h040);
    wr(8'h03, 8'h00);
    rd(8'h03, 10'h040);
    pulse(1);
    rd(8'h03, 10'h044);
    pulse(2);
    rd(8'h03, 10'h060);
    wr(8'h03, 8'h60);
    pulse(1);
    wr(8'h03, 8'h04);
    rd(8'h03, 10'h000);
    wr(8'h04, 8'hFF);
    rd(8'h04, 10'h092);
    pulse(3);
    rd(8'h03, 10'h080);
    chk("irq", 10'h001, {9'h0, irq_o});
    wr(8'h04, 8'h10);
    settle;
    chk("irq", 10'h000, {9'h0, irq_o});
    wr(8'h03, 8'h80);
    wr(8'h05, 8'h80);
    rd(8'h05, 10'h020);
    lock_raw_i <= 1'b1;
    settle;
    chk("irq", 10'h001, {9'h0, irq_o});
    rd(8'h03, 10'h018);
    wr(8'h05, 8'h80);
    rd(8'h05, 10'h0A0);
    wr(8'h02, 8'h05);
    rd(8'h02, 10'h000);
    stop_mode_i <= 1'b1;
    settle;
    chk("osc", 10'h000, {9'h0, osc_run_o});
    stop_mode_i <= 1'b0;
    rd(8'h05, 10'h020);
    wr(8'h05, 8'h80);
    self_clock_status_i <= 1'b1;
    settle;
    rd(8'h03, 10'h013);
    rd(8'h05, 10'h020);
    self_clock_status_i <= 1'b0;
    settle;
    wr(8'h03, 8'h12);
    rd(8'h03, 10'h008);
    d = lfsr[7:0];
    wr(8'h02, d);
    rd(8'h02, {2'h0, d & 8'h1F});
    // A value of one halves the sampled VCO; zero passes it straight on.
    for (int k = 1; k >= 0; k--) begin
      wr(8'h02, 8'(k));
      for (int i = 0; i < 24; i++) begin
        @(posedge sys_clk_i);
        if (i > 0) chk("synth", {9'h0, ((k == 1) ? (ps ^ pv) : pv)},
                       {9'h0, synth_clock_o});
        ps = synth_clock_o;
        pv = vco_clock_i;
      end
    end
    rd(8'h06, 10'h200);
    wr(8'h10, 8'hFF);
    // A second reset restores the one write allowed to the watchdog bit.
    resetn_i <= 1'b0;
    settle;
    resetn_i <= 1'b1;
    wr(8'h05, 8'h4B);
    rd(8'h05, 10'h06B);
    wr(8'h05, 8'h4A);
    rd(8'h05, 10'h06B);
    special_mode_i <= 1'b1;
    wr(8'h05, 8'hCA);
    rd(8'h05, 10'h0EA);
    synth_power_on_i <= 1'b1;
    wait_mode_i <= 1'b1;
    settle;
    chk("sel", 10'h000, {9'h0, system_from_synth_o});
    chk("tinit", 10'h001, {9'h0, timer_init_o});
    chk("wdrun", 10'h001, {9'h0, watchdog_run_o});
    chk("spwr", 10'h000, {9'h0, synth_power_o});
    wait_mode_i <= 1'b0;
    stop_mode_i <= 1'b1;
    settle;
    chk("spwr", 10'h001, {9'h0, synth_power_o});
    chk("osc", 10'h001, {9'h0, osc_run_o});
    stop_mode_i <= 1'b0;
    settle;
    close_out;
  end
endmodule
bind cgss_top cgss_chk u_chk (.*);
